// ### rtl/sas_defs.vh
// Timing and encoding constants for the smoke alarm sequencer.
//
// Summary of operation
// - Standby internal period is 1.67 s and paces the standby strobes, LED pulses and chirps.
// - Each period power sensing for 10.5 ms and latch the smoke comparator.
// - Every 40 s pulse the LED 10.5 ms and latch low battery at pulse end.
// - No smoke sampling during battery test, chirp or alarm horn.
// - In alarm the internal period shortens to 41.5 ms.
// - In local alarm the LED pulses 10.5 ms every second.
// - Local alarm drives the interconnect line high.
// - Interconnect drive starts 3 s after the local alarm begins.
// - Remote alarm horn starts 0.45 s to 2.2 s after the line goes active.
// - LED stays off in an alarm caused only by the interconnect.
// - After local alarm ends, sink the interconnect for one standby period.
// - Charge dump only after local alarm, never after remote alarm.
// - Interconnect input qualified for 500 ms; 450 ms pulses never trigger.
// - Low battery without alarm chirps the horn 10.5 ms every 40 s.
// - No low battery chirp in local or remote alarm.
// - Falling edge on the timer trigger starts an 8 minute timer.
// - While the timer runs, the sensitivity strobe follows the sensing strobe.
// - Timer running and no alarm: LED blinks every 10 s.
// - Power-up reset clears alarm, battery, timer and interconnect state.
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH

`define SAS_CLK_PERIOD_NS 20
`define SAS_TICK_US       100
`define SAS_TICK_CYCLES   ((`SAS_TICK_US * 1000) / `SAS_CLK_PERIOD_NS)
`define SAS_TICK_W        16
`define SAS_CNT_W         24

`define SAS_T_PER_STBY_US 1670000
`define SAS_T_PER_ALM_US  41500
`define SAS_T_STROBE_US   10500
`define SAS_T_LBAT_US     40000000
`define SAS_T_LED_ALM_US  1000000
`define SAS_T_LED_TMR_US  10000000
`define SAS_T_HORN_ON_US  166000
`define SAS_T_HORN_OFF_US 83000
`define SAS_T_IO_DLY_US   3000000
`define SAS_T_IO_FILT_US  500000
`define SAS_T_TIMER_US    480000000

`define SAS_TK(us) ((us) / `SAS_TICK_US)

`define SAS_SYNC_SMOKE 0
`define SAS_SYNC_LBAT  1
`define SAS_SYNC_IO    2
`define SAS_SYNC_TRIG  3
`define SAS_SYNC_W     4

`endif

// ### rtl/sas_sync.v
// Two flip-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module sas_sync #(
	parameter WIDTH = 1
)(
	// Clock and reset
	input  wire             clk,
	input  wire             reset,
	// Data
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;

	always @(posedge clk)
	begin
		if (reset)
		begin
			meta_ff <= {WIDTH{1'b0}};
			sync_ff <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule

// ### rtl/sas_tick.v
// Base time tick generator: one pulse every CYCLES clocks.
`timescale 1ns/1ps
`include "sas_defs.vh"
module sas_tick #(
	parameter CYCLES = `SAS_TICK_CYCLES
)(
	// Clock and reset
	input  wire clk,
	input  wire reset,
	// Tick
	output wire tick
);

	localparam integer           LAST_I = CYCLES - 1;
	localparam [`SAS_TICK_W-1:0] LAST   = LAST_I[`SAS_TICK_W-1:0];

	reg [`SAS_TICK_W-1:0] cnt_ff;
	reg                   tick_ff;

	always @(posedge clk)
	begin
		if (reset)
		begin
			cnt_ff  <= {`SAS_TICK_W{1'b0}};
			tick_ff <= 1'b0;
		end
		else if (cnt_ff == LAST)
		begin
			cnt_ff  <= {`SAS_TICK_W{1'b0}};
			tick_ff <= 1'b1;
		end
		else
		begin
			cnt_ff  <= cnt_ff + 1'b1;
			tick_ff <= 1'b0;
		end
	end

	assign tick = tick_ff;

endmodule

// ### rtl/sas_seq.v
// Sequencing core of the smoke alarm: strobes, indications, interconnect and timer.
`timescale 1ns/1ps
`include "sas_defs.vh"
module sas_seq #(
	parameter TICK_CYCLES = `SAS_TICK_CYCLES
)(
	// Clock and reset
	input  wire clk,
	input  wire reset,
	// Sensing
	input  wire smoke_cmp,
	input  wire lowbat_cmp,
	output wire sense_strobe,
	// Indication
	output wire led_drive,
	output wire horn_drive_a,
	output wire horn_drive_b,
	// Interconnect pin
	input  wire io_in,
	output wire io_out,
	output wire io_oe,
	// Timer
	input  wire timer_trigger_input,
	output wire sensitivity_strobe_output,
	output wire sensitivity_strobe_oe,
	// Status
	output wire local_alarm,
	output wire remote_alarm,
	output wire low_battery,
	output wire timer_active
);

	// ************************************************************
	// Constants
	// ************************************************************
	localparam W = `SAS_CNT_W;

	// Converts a time in microseconds to a tick count cut to the counter width.
	function [W-1:0] to_ticks;
		input integer us;
		integer       t;
		begin
			t        = `SAS_TK(us);
			to_ticks = t[W-1:0];
		end
	endfunction

	localparam [W-1:0] PER_STBY = to_ticks(`SAS_T_PER_STBY_US);
	localparam [W-1:0] PER_ALM  = to_ticks(`SAS_T_PER_ALM_US);
	localparam [W-1:0] STB_LEN  = to_ticks(`SAS_T_STROBE_US);
	localparam [W-1:0] LBAT_LEN = to_ticks(`SAS_T_LBAT_US);
	localparam [W-1:0] LED_ALM  = to_ticks(`SAS_T_LED_ALM_US);
	localparam [W-1:0] LED_TMR  = to_ticks(`SAS_T_LED_TMR_US);
	localparam [W-1:0] HORN_ON  = to_ticks(`SAS_T_HORN_ON_US);
	localparam [W-1:0] HORN_OFF = to_ticks(`SAS_T_HORN_OFF_US);
	localparam [W-1:0] IO_DLY   = to_ticks(`SAS_T_IO_DLY_US);
	localparam [W-1:0] IO_FILT  = to_ticks(`SAS_T_IO_FILT_US);
	localparam [W-1:0] TMR_LEN  = to_ticks(`SAS_T_TIMER_US);
	localparam [W-1:0] ONE      = 24'h000001;
	localparam [W-1:0] ZERO     = 24'h000000;

	// Alarm states, one-hot.
	localparam [2:0] ST_STBY   = 3'h1;
	localparam [2:0] ST_LOCAL  = 3'h2;
	localparam [2:0] ST_REMOTE = 3'h4;

	// Strobe kinds, one-hot.
	localparam [2:0] K_SENSE = 3'h1;
	localparam [2:0] K_LBAT  = 3'h2;
	localparam [2:0] K_CHIRP = 3'h4;

	// ************************************************************
	// Input synchronisation and time base
	// ************************************************************
	wire [`SAS_SYNC_W-1:0] sync_in;
	wire [`SAS_SYNC_W-1:0] sync_q;
	wire                   tick;

	assign sync_in[`SAS_SYNC_SMOKE] = smoke_cmp;
	assign sync_in[`SAS_SYNC_LBAT]  = lowbat_cmp;
	assign sync_in[`SAS_SYNC_IO]    = io_in;
	assign sync_in[`SAS_SYNC_TRIG]  = timer_trigger_input;

	sas_sync #(
		.WIDTH(`SAS_SYNC_W)
	) u_sync (
		.clk     (clk),
		.reset   (reset),
		.async_in(sync_in),
		.sync_out(sync_q)
	);

	sas_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clk  (clk),
		.reset(reset),
		.tick (tick)
	);

	wire smoke_s = sync_q[`SAS_SYNC_SMOKE];
	wire lbat_s  = sync_q[`SAS_SYNC_LBAT];
	wire io_s    = sync_q[`SAS_SYNC_IO];
	wire trig_s  = sync_q[`SAS_SYNC_TRIG];

	// ************************************************************
	// State registers
	// ************************************************************
	reg [2:0]   state_ff;
	reg [W-1:0] per_cnt_ff;
	reg         stb_ff;
	reg [2:0]   kind_ff;
	reg [W-1:0] stb_cnt_ff;
	reg         led_ff;
	reg         smoke_ff;
	reg         lbat_ff;
	reg [W-1:0] lb_cnt_ff;
	reg         lb_due_ff;
	reg         chirp_due_ff;
	reg [W-1:0] led_cnt_ff;
	reg         led_due_ff;
	reg         horn_alm_ff;
	reg         horn_ph_on_ff;
	reg [W-1:0] horn_cnt_ff;
	reg         horn_a_ff;
	reg         horn_b_ff;
	reg [W-1:0] io_dly_cnt_ff;
	reg         io_drive_ff;
	reg         dump_ff;
	reg [W-1:0] dump_cnt_ff;
	reg [W-1:0] filt_cnt_ff;
	reg         io_qual_ff;
	reg         trig_d_ff;
	reg         tmr_run_ff;
	reg [W-1:0] tmr_cnt_ff;

	wire in_alarm  = ~state_ff[0];
	wire in_local  = state_ff[1];
	wire led_mode  = in_local | (tmr_run_ff & ~in_alarm);
	wire [W-1:0] per_len = in_alarm ? PER_ALM : PER_STBY;
	wire [W-1:0] led_len = in_local ? LED_ALM : LED_TMR;

	// ************************************************************
	// Internal oscillator period and strobe
	// ************************************************************
	wire osc_edge = tick & (per_cnt_ff >= per_len - ONE);
	wire stb_end  = stb_ff & tick & (stb_cnt_ff == STB_LEN - ONE);

	reg [2:0] nxt_kind;

	always @*
	begin
		if (chirp_due_ff & ~in_alarm)
			nxt_kind = K_CHIRP;
		else if (lb_due_ff & ~in_alarm)
			nxt_kind = K_LBAT;
		else
			nxt_kind = K_SENSE;
	end

	always @(posedge clk)
	begin
		if (reset)
		begin
			per_cnt_ff <= ZERO;
			stb_ff     <= 1'b0;
			kind_ff    <= K_SENSE;
			stb_cnt_ff <= ZERO;
			led_ff     <= 1'b0;
		end
		else
		begin
			if (osc_edge)
				per_cnt_ff <= ZERO;
			else if (tick)
				per_cnt_ff <= per_cnt_ff + ONE;

			if (osc_edge & ~stb_ff)
			begin
				stb_ff     <= 1'b1;
				kind_ff    <= nxt_kind;
				stb_cnt_ff <= ZERO;
				led_ff     <= (nxt_kind == K_LBAT) | (led_due_ff & led_mode);
			end
			else if (stb_end)
			begin
				stb_ff <= 1'b0;
				led_ff <= 1'b0;
			end
			else if (stb_ff & tick)
				stb_cnt_ff <= stb_cnt_ff + ONE;
		end
	end

	// ************************************************************
	// Comparator latches and low battery scheduling
	// ************************************************************
	wire smoke_ok = ~horn_alm_ff;
	wire stb_start = osc_edge & ~stb_ff;

	always @(posedge clk)
	begin
		if (reset)
		begin
			smoke_ff     <= 1'b0;
			lbat_ff      <= 1'b0;
			lb_cnt_ff    <= ZERO;
			lb_due_ff    <= 1'b0;
			chirp_due_ff <= 1'b0;
		end
		else
		begin
			case (kind_ff)
				K_SENSE:
				begin
					if (stb_end & smoke_ok)
						smoke_ff <= smoke_s;
				end
				K_LBAT:
				begin
					if (stb_end)
						lbat_ff <= lbat_s;
				end
				K_CHIRP:
				begin
					lbat_ff <= lbat_ff;
				end
				default:
				begin
					smoke_ff <= 1'b0;
				end
			endcase

			if (tick & (lb_cnt_ff >= LBAT_LEN - ONE))
			begin
				lb_cnt_ff <= ZERO;
				lb_due_ff <= 1'b1;
			end
			else
			begin
				if (tick)
					lb_cnt_ff <= lb_cnt_ff + ONE;
				if (stb_start & (nxt_kind == K_LBAT))
					lb_due_ff <= 1'b0;
			end

			if (stb_end & (kind_ff == K_LBAT) & lbat_s)
				chirp_due_ff <= 1'b1;
			else if ((stb_start & (nxt_kind == K_CHIRP)) | in_alarm)
				chirp_due_ff <= 1'b0;
		end
	end

	// ************************************************************
	// LED interval in local alarm and timer mode
	// ************************************************************
	always @(posedge clk)
	begin
		if (reset)
		begin
			led_cnt_ff <= ZERO;
			led_due_ff <= 1'b0;
		end
		else if (~led_mode)
		begin
			led_cnt_ff <= ZERO;
			led_due_ff <= 1'b0;
		end
		else if (tick & (led_cnt_ff >= led_len - ONE))
		begin
			led_cnt_ff <= ZERO;
			led_due_ff <= 1'b1;
		end
		else
		begin
			if (tick)
				led_cnt_ff <= led_cnt_ff + ONE;
			if (stb_start)
				led_due_ff <= 1'b0;
		end
	end

	// ************************************************************
	// Alarm state machine
	// ************************************************************
	reg [2:0] nxt_state;

	always @*
	begin
		case (state_ff)
			ST_STBY:
				nxt_state = smoke_ff ? ST_LOCAL : (io_qual_ff ? ST_REMOTE : ST_STBY);
			ST_LOCAL:
				nxt_state = smoke_ff ? ST_LOCAL : ST_STBY;
			ST_REMOTE:
				nxt_state = smoke_ff ? ST_LOCAL : (io_qual_ff ? ST_REMOTE : ST_STBY);
			default:
				nxt_state = ST_STBY;
		endcase
	end

	always @(posedge clk)
	begin
		if (reset)
			state_ff <= ST_STBY;
		else
			state_ff <= nxt_state;
	end

	// ************************************************************
	// Horn pattern and low battery chirp
	// ************************************************************
	wire alarm_next = ~nxt_state[0];
	wire chirp_on   = stb_ff & (kind_ff == K_CHIRP);

	always @(posedge clk)
	begin
		if (reset)
		begin
			horn_alm_ff   <= 1'b0;
			horn_ph_on_ff <= 1'b0;
			horn_cnt_ff   <= ZERO;
			horn_a_ff     <= 1'b0;
			horn_b_ff     <= 1'b0;
		end
		else
		begin
			if (~in_alarm & alarm_next)
			begin
				horn_alm_ff   <= 1'b1;
				horn_ph_on_ff <= 1'b1;
				horn_cnt_ff   <= ZERO;
			end
			else if (~alarm_next)
			begin
				horn_alm_ff   <= 1'b0;
				horn_ph_on_ff <= 1'b0;
				horn_cnt_ff   <= ZERO;
			end
			else if (tick & horn_ph_on_ff & (horn_cnt_ff == HORN_ON - ONE))
			begin
				horn_alm_ff   <= 1'b0;
				horn_ph_on_ff <= 1'b0;
				horn_cnt_ff   <= ZERO;
			end
			else if (tick & ~horn_ph_on_ff & (horn_cnt_ff == HORN_OFF - ONE))
			begin
				horn_alm_ff   <= 1'b1;
				horn_ph_on_ff <= 1'b1;
				horn_cnt_ff   <= ZERO;
			end
			else if (tick)
				horn_cnt_ff <= horn_cnt_ff + ONE;

			horn_a_ff <= horn_alm_ff | chirp_on;
			horn_b_ff <= ~(horn_alm_ff | chirp_on) & (in_alarm | chirp_on);
		end
	end

	// ************************************************************
	// Interconnect drive, charge dump and input filter
	// ************************************************************
	always @(posedge clk)
	begin
		if (reset)
		begin
			io_dly_cnt_ff <= ZERO;
			io_drive_ff   <= 1'b0;
			dump_ff       <= 1'b0;
			dump_cnt_ff   <= ZERO;
			filt_cnt_ff   <= ZERO;
			io_qual_ff    <= 1'b0;
		end
		else
		begin
			if (~in_local)
			begin
				io_dly_cnt_ff <= ZERO;
				io_drive_ff   <= 1'b0;
			end
			else if (tick & (io_dly_cnt_ff == IO_DLY - ONE))
				io_drive_ff <= 1'b1;
			else if (tick & ~io_drive_ff)
				io_dly_cnt_ff <= io_dly_cnt_ff + ONE;

			if (in_local & ~nxt_state[1])
			begin
				dump_ff     <= 1'b1;
				dump_cnt_ff <= ZERO;
			end
			else if (alarm_next | (tick & (dump_cnt_ff == PER_STBY - ONE)))
				dump_ff <= 1'b0;
			else if (tick & dump_ff)
				dump_cnt_ff <= dump_cnt_ff + ONE;

			if (~io_s | in_local | dump_ff)
			begin
				filt_cnt_ff <= ZERO;
				io_qual_ff  <= 1'b0;
			end
			else if (tick & (filt_cnt_ff == IO_FILT - ONE))
				io_qual_ff <= 1'b1;
			else if (tick & ~io_qual_ff)
				filt_cnt_ff <= filt_cnt_ff + ONE;
		end
	end

	// ************************************************************
	// Reduced-sensitivity timer
	// ************************************************************
	always @(posedge clk)
	begin
		if (reset)
		begin
			trig_d_ff  <= 1'b0;
			tmr_run_ff <= 1'b0;
			tmr_cnt_ff <= ZERO;
		end
		else
		begin
			trig_d_ff <= trig_s;
			if (trig_d_ff & ~trig_s)
			begin
				tmr_run_ff <= 1'b1;
				tmr_cnt_ff <= ZERO;
			end
			else if (tick & tmr_run_ff & (tmr_cnt_ff == TMR_LEN - ONE))
				tmr_run_ff <= 1'b0;
			else if (tick & tmr_run_ff)
				tmr_cnt_ff <= tmr_cnt_ff + ONE;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign sense_strobe              = stb_ff;
	assign led_drive                 = led_ff;
	assign horn_drive_a              = horn_a_ff;
	assign horn_drive_b              = horn_b_ff;
	assign io_out                    = io_drive_ff;
	assign io_oe                     = io_drive_ff | dump_ff;
	assign sensitivity_strobe_output = 1'b0;
	assign sensitivity_strobe_oe     = tmr_run_ff & stb_ff;
	assign local_alarm               = in_local;
	assign remote_alarm              = state_ff[2];
	assign low_battery               = lbat_ff;
	assign timer_active              = tmr_run_ff;

endmodule

// ### test/sas_peer.sv
// Model of another alarm unit sharing the interconnect wire.
`timescale 1ns/1ps
module sas_peer (
	// Clock and reset
	input  wire clk,
	input  wire reset,
	// Control and wire
	input  wire alarm_req,
	input  wire line,
	output wire drive,
	output wire seen_high
);
	reg drive_ff;
	reg seen_ff;
	// A unit in alarm drives the wire; it notes any high level it did not drive itself.
	always @(posedge clk)
	begin
		if (reset)
		begin
			drive_ff <= 1'b0;
			seen_ff  <= 1'b0;
		end
		else
		begin
			drive_ff <= alarm_req;
			seen_ff  <= seen_ff | (line & ~drive_ff);
		end
	end
	assign drive     = drive_ff;
	assign seen_high = seen_ff;
endmodule

// ### test/sas_seq_assertions.sv
// Concurrent checks on the sequencer ports.
`timescale 1ns/1ps
module sas_seq_assertions #(
	parameter TICK_CYCLES = 2
)(
	// Clock and reset
	input wire clk,
	input wire reset,
	// Pins
	input wire smoke_cmp,
	input wire lowbat_cmp,
	input wire sense_strobe,
	input wire led_drive,
	input wire horn_drive_a,
	input wire horn_drive_b,
	input wire io_in,
	input wire io_out,
	input wire io_oe,
	input wire timer_trigger_input,
	input wire sensitivity_strobe_output,
	input wire sensitivity_strobe_oe,
	input wire local_alarm,
	input wire remote_alarm,
	input wire low_battery,
	input wire timer_active
);
	localparam int T      = TICK_CYCLES;
	localparam int ON     = 1660 * T;
	localparam int OFF    = 830 * T;
	localparam int DLY    = 30000 * T;
	localparam int TS_MAX = 2 * T + 6;
	reg [31:0] hcnt_ff;
	reg [31:0] la_ff;
	reg [31:0] io_ff;
	reg        last_a_ff;
	// ****************************************
	// Phase counters for horn, alarm and wire.
	// ****************************************
	always @(posedge clk)
	begin
		last_a_ff <= reset ? 1'b0 : horn_drive_a;
		hcnt_ff   <= (reset || horn_drive_a != last_a_ff) ? 32'h1 : hcnt_ff + 32'h1;
		la_ff     <= (reset || !local_alarm) ? 32'h0 : la_ff + 32'h1;
		io_ff     <= (reset || !io_in) ? 32'h0 : io_ff + 32'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_on_end;
		local_alarm && $fell(horn_drive_a);
	endsequence
	sequence s_dump;
		io_oe && !io_out;
	endsequence
	a_horn_on: assert property (s_on_end |-> hcnt_ff >= ON - 2 * T && hcnt_ff <= ON + 2 * T)
		else $error("horn on time wrong");
	a_horn_off: assert property (local_alarm && $rose(horn_drive_a) && la_ff > ON |->
		hcnt_ff >= OFF - 2 * T && hcnt_ff <= OFF + 2 * T)
		else $error("horn off time wrong");
	a_horn_start: assert property ($rose(local_alarm) |-> ##[1:3] horn_drive_a)
		else $error("horn late in alarm");
	a_horn_comp: assert property (local_alarm && la_ff > 4 |-> horn_drive_b != horn_drive_a)
		else $error("horn outputs not complementary");
	a_remote_led: assert property (remote_alarm && !local_alarm |-> !$rose(led_drive))
		else $error("led lit in remote alarm");
	a_sens_follow: assert property (sensitivity_strobe_oe == (timer_active && sense_strobe) &&
		!sensitivity_strobe_output)
		else $error("sensitivity strobe mismatch");
	a_dump_start: assert property ($fell(local_alarm) |-> ##[0:2] s_dump)
		else $error("no dump after local alarm");
	a_no_dump: assert property ($fell(remote_alarm) && !local_alarm && !io_oe |-> ##1 !io_oe [*4])
		else $error("dump after remote alarm");
	a_io_delay: assert property ($rose(io_oe && io_out) |-> la_ff >= DLY - 2 * T && la_ff <= DLY + 2 * T)
		else $error("wire drive delay wrong");
	a_io_filter: assert property ($rose(remote_alarm) |-> io_ff > 4500 * T && io_ff <= 22000 * T)
		else $error("wire filter wrong");
	a_timer_start: assert property ($fell(timer_trigger_input) |-> ##[1:TS_MAX] timer_active)
		else $error("timer did not start");
	a_reset_clear: assert property ($past(reset) |-> !local_alarm && !remote_alarm && !low_battery &&
		!timer_active && !io_oe && !horn_drive_a && !led_drive)
		else $error("state not cleared");
endmodule
bind sas_seq sas_seq_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .reset(reset),
	.smoke_cmp(smoke_cmp), .lowbat_cmp(lowbat_cmp), .sense_strobe(sense_strobe), .led_drive(led_drive),
	.horn_drive_a(horn_drive_a), .horn_drive_b(horn_drive_b), .io_in(io_in), .io_out(io_out),
	.io_oe(io_oe), .timer_trigger_input(timer_trigger_input),
	.sensitivity_strobe_output(sensitivity_strobe_output), .sensitivity_strobe_oe(sensitivity_strobe_oe),
	.local_alarm(local_alarm), .remote_alarm(remote_alarm), .low_battery(low_battery),
	.timer_active(timer_active));

// ### test/test_smoke_alarm_sequencer.sv
// Self-checking bench for the smoke alarm sequencer.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WAIT(c, n) begin w = 0; while (!(c) && w < (n)) begin @(posedge clk); #1; w++; end end
module test_smoke_alarm_sequencer;
	// One clock per tick speeds all timing, as a fast oscillator clock would; the set point test is not modelled.
	localparam T = 1;
	reg  clk       = 1'b0;
	reg  reset     = 1'b1;
	reg  smoke_cmp = 1'b0;
	reg  lowbat    = 1'b0;
	reg  trig_in   = 1'b0;
	reg  peer_req  = 1'b0;
	wire strobe, led, horn_a, horn_b, io_out, io_oe, ss_out, ss_oe;
	wire local_alarm, remote_alarm, low_battery, timer_active, peer_drive, peer_seen;
	wire io_line;
	int  n_errors  = 0;
	int  checked   = 0;
	int  w         = 0;
	int  cycles    = 0;
	int  c0        = 0;
	// The wire is pulled low unless someone drives it; the dump sink wins.
	assign io_line = io_oe ? io_out : peer_drive;
	sas_seq #(.TICK_CYCLES(T)) DUT (.clk(clk), .reset(reset), .smoke_cmp(smoke_cmp), .lowbat_cmp(lowbat),
		.sense_strobe(strobe), .led_drive(led), .horn_drive_a(horn_a), .horn_drive_b(horn_b),
		.io_in(io_line), .io_out(io_out), .io_oe(io_oe), .timer_trigger_input(trig_in),
		.sensitivity_strobe_output(ss_out), .sensitivity_strobe_oe(ss_oe), .local_alarm(local_alarm),
		.remote_alarm(remote_alarm), .low_battery(low_battery), .timer_active(timer_active));
	sas_peer u_peer (.clk(clk), .reset(reset), .alarm_req(peer_req), .line(io_line), .drive(peer_drive),
		.seen_high(peer_seen));
	// ****************************************
	// Scenarios.
	// ****************************************
	task results;
		$display("n_errors=%0d checked=%0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task t_reset;
		`CHK({local_alarm, remote_alarm, low_battery, timer_active, io_oe, led, horn_a}, 7'h00)
	endtask
	task t_remote;
		@(posedge clk);
		peer_req <= 1'b1;
		repeat (4500 * T) @(posedge clk);
		peer_req <= 1'b0;
		repeat (20) @(posedge clk);
		#1;
		`CHK(remote_alarm, 1'b0)
		@(posedge clk);
		peer_req <= 1'b1;
		`WAIT(horn_a, 30000 * T)
		`CHK(w > 4500 * T && w <= 22000 * T, 1'b1)
		`CHK({remote_alarm, led}, 2'b10)
		@(posedge clk);
		peer_req <= 1'b0;
		`WAIT(!remote_alarm, 20)
		repeat (10) @(posedge clk);
		#1;
		`CHK(io_oe, 1'b0)
	endtask
	task t_local;
		`WAIT(!strobe, 200 * T)
		@(posedge clk);
		smoke_cmp <= 1'b1;
		trig_in   <= 1'b1;
		repeat (8) @(posedge clk);
		trig_in <= 1'b0;
		`WAIT(timer_active, 20)
		`CHK(timer_active, 1'b1)
		`WAIT(strobe, 17000 * T)
		`CHK(ss_oe, 1'b1)
		`WAIT(!strobe, 200 * T)
		`CHK(w >= 104 * T && w <= 106 * T, 1'b1)
		`WAIT(local_alarm, 10)
		c0 = cycles;
		`CHK(local_alarm, 1'b1)
		`WAIT(horn_a, 4)
		`WAIT(!horn_a, 2000 * T)
		`CHK(w >= 1659 * T && w <= 1661 * T, 1'b1)
		`WAIT(horn_a, 1000 * T)
		`CHK(w >= 829 * T && w <= 831 * T, 1'b1)
		`WAIT(!led, 200 * T)
		`WAIT(led, 11000 * T)
		`WAIT(!led, 200 * T)
		`CHK(w >= 104 * T && w <= 106 * T, 1'b1)
		`WAIT(io_out, 30000 * T)
		`CHK(cycles - c0 >= 29998 * T && cycles - c0 <= 30002 * T, 1'b1)
		repeat (2) @(posedge clk);
		#1;
		`CHK({io_oe, io_out, peer_seen}, 3'h7)
		@(posedge clk);
		smoke_cmp <= 1'b0;
		`WAIT(!local_alarm, 4000 * T)
		repeat (2) @(posedge clk);
		#1;
		`CHK({local_alarm, io_oe, io_out, peer_seen}, 4'h5)
		`WAIT(!io_oe, 17000 * T)
		`CHK(w >= 16690 * T && w <= 16701 * T, 1'b1)
		`CHK(timer_active, 1'b1)
	endtask
	initial
	begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			n_errors++;
			results();
		end
	end
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_remote();
		t_local();
		@(posedge clk);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		results();
	end
endmodule
